// [inc/timer_pkg.sv]
package timer_pkg;

  // ==========================================================================
  // Waveform modes
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_MAX   = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_OCR   = 3'h5;
  localparam logic [2:0] MODE_FAST_OCR = 3'h7;

  // ==========================================================================
  // Compare-output settings
  localparam logic [1:0] OUT_NONE   = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR  = 2'h2;
  localparam logic [1:0] OUT_SET    = 2'h3;

  // ==========================================================================
  // Counter limits and count step
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP   = 8'h01;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] setting_a;
    logic [1:0] setting_b;
    logic       dir_a;
    logic       dir_b;
    logic       port_a;
    logic       port_b;
  } cfg_s;

  typedef struct packed {
    logic       count_wr;
    logic       cmp_a_wr;
    logic       cmp_b_wr;
    logic [7:0] data;
    logic       clr_ovf;
    logic       clr_cmp_a;
    logic       clr_cmp_b;
  } cpu_s;

  typedef struct packed {
    logic [7:0] active;
    logic [7:0] buffer;
    logic       oc;
    logic       pend;
    logic       up_hit;
    logic       fix;
    logic       flag;
    logic       pin;
    logic       pin_oe;
  } chan_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic       down;
    logic       blk;
    logic       ovf;
    chan_s      a;
    chan_s      b;
  } state_s;

  localparam state_s STATE_RST = '0;

endpackage

// [design/pwm_timer.sv]
`timescale 1ns/1ns
`default_nettype none

module pwm_timer
  import timer_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       timer_tick,
  input  wire cfg_s       cfg,
  input  wire cpu_s       cpu,
  output logic [7:0]      count_value,
  output logic [7:0]      compare_value_a,
  output logic [7:0]      compare_value_b,
  output logic            overflow_flag,
  output logic            compare_flag_a,
  output logic            compare_flag_b,
  output logic            compare_output_a,
  output logic            compare_output_a_oe,
  output logic            compare_output_b,
  output logic            compare_output_b_oe
);

  // ==========================================================================
  // Mode decode
  state_s     state_reg;
  state_s     state_next;
  logic       fast;
  logic       pc;
  logic       pwm;
  logic [7:0] top;
  logic       at_top;
  logic       match_a;

  assign fast    = (cfg.mode == MODE_FAST_MAX) || (cfg.mode == MODE_FAST_OCR);
  assign pc      = (cfg.mode == MODE_PC_MAX) || (cfg.mode == MODE_PC_OCR);
  assign pwm     = fast || pc;
  assign top     = (cfg.mode == MODE_FAST_OCR || cfg.mode == MODE_PC_OCR) ?
                   state_reg.a.active : CNT_MAX;
  assign at_top  = state_reg.cnt == top;
  assign match_a = !state_reg.blk && state_reg.cnt == state_reg.a.active;

  // ==========================================================================
  // Channel step, shared by both compare channels
  function automatic chan_s chan_step(
    input chan_s      c,
    input logic [1:0] set,
    input logic       tk,
    input logic       blocked,
    input logic [7:0] v,
    input logic       down,
    input logic       clr,
    input logic       wr,
    input logic [7:0] wd,
    input logic       dir,
    input logic       port,
    input logic       chan_a
  );
    chan_s n;
    logic  hit;
    logic  upm;
    n   = c;
    hit = tk && !blocked && v == c.active;
    upm = (!down && v != top) || v == CNT_BOTTOM;
    if (tk) begin
      n.pend = hit;
    end
    n.flag = (c.flag & ~clr) | (tk & c.pend);
    if (hit) begin
      if (pc) begin
        if (set == OUT_CLEAR || set == OUT_SET) begin
          n.oc = upm ? (set == OUT_SET) : (set == OUT_CLEAR);
        end
        if (upm) begin
          n.up_hit = 1'b1;
        end
      end else if (fast) begin
        if (set == OUT_CLEAR || set == OUT_SET) begin
          n.oc = set == OUT_SET;
        end
        if (set == OUT_TOGGLE && chan_a) begin
          n.oc = ~c.oc;
        end
      end else begin
        if (set == OUT_TOGGLE) begin
          n.oc = ~c.oc;
        end else if (set != OUT_NONE) begin
          n.oc = set == OUT_SET;
        end
      end
    end
    if (tk && fast && v == top) begin
      // bottom action wins over match at top
      if (set == OUT_CLEAR || set == OUT_SET) begin
        n.oc = set == OUT_CLEAR;
      end
      n.active = c.buffer;
    end
    if (tk && pc && !down && v == top) begin
      n.active = c.buffer;
      n.fix    = !c.up_hit;
      n.up_hit = 1'b0;
    end
    if (tk && pc && down && v == CNT_BOTTOM) begin
      // late up-match transition, skipped while compare sits at top
      if (c.fix && c.active != top && (set == OUT_CLEAR || set == OUT_SET)) begin
        n.oc = set == OUT_SET;
      end
      n.fix = 1'b0;
    end
    if (wr) begin
      n.buffer = wd;
      if (!pwm) begin
        n.active = wd;
      end
    end
    n.pin_oe = dir;
    n.pin    = (set != OUT_NONE) ? n.oc : port;
    return n;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    if (timer_tick) begin
      state_next.blk = 1'b0;
      if (pc) begin
        // one tick at top, then reverse
        if (top == CNT_BOTTOM) begin
          state_next.cnt = CNT_BOTTOM;
        end else if (!state_reg.down && at_top) begin
          state_next.down = 1'b1;
          state_next.cnt  = state_reg.cnt - CNT_STEP;
        end else if (state_reg.down && state_reg.cnt == CNT_BOTTOM) begin
          state_next.down = 1'b0;
          state_next.cnt  = state_reg.cnt + CNT_STEP;
        end else begin
          state_next.cnt = state_reg.down ? state_reg.cnt - CNT_STEP :
                           state_reg.cnt + CNT_STEP;
        end
      end else begin
        state_next.down = 1'b0;
        if (fast && at_top) begin
          state_next.cnt = CNT_BOTTOM;
        // CTC clear on exact match only
        end else if (cfg.mode == MODE_CTC && match_a) begin
          state_next.cnt = CNT_BOTTOM;
        end else begin
          state_next.cnt = state_reg.cnt + CNT_STEP;
        end
      end
    end
    if (cpu.count_wr) begin
      state_next.cnt = cpu.data;
      state_next.blk = 1'b1;
    end
    state_next.ovf = (state_reg.ovf & ~cpu.clr_ovf) |
                     (timer_tick && (fast ? at_top :
                      pc ? (state_reg.down && state_reg.cnt == CNT_STEP) ||
                           (top == CNT_BOTTOM) :
                      state_reg.cnt == CNT_MAX));
    state_next.a = chan_step(state_reg.a, cfg.setting_a, timer_tick, state_reg.blk,
                             state_reg.cnt, state_reg.down, cpu.clr_cmp_a,
                             cpu.cmp_a_wr, cpu.data, cfg.dir_a, cfg.port_a, 1'b1);
    state_next.b = chan_step(state_reg.b, cfg.setting_b, timer_tick, state_reg.blk,
                             state_reg.cnt, state_reg.down, cpu.clr_cmp_b,
                             cpu.cmp_b_wr, cpu.data, cfg.dir_b, cfg.port_b, 1'b0);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign count_value         = state_reg.cnt;
  assign compare_value_a     = state_reg.a.active;
  assign compare_value_b     = state_reg.b.active;
  assign overflow_flag       = state_reg.ovf;
  assign compare_flag_a      = state_reg.a.flag;
  assign compare_flag_b      = state_reg.b.flag;
  assign compare_output_a    = state_reg.a.pin;
  assign compare_output_a_oe = state_reg.a.pin_oe;
  assign compare_output_b    = state_reg.b.pin;
  assign compare_output_b_oe = state_reg.b.pin_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_NORMAL_INC: assert property (
    timer_tick && cfg.mode == MODE_NORMAL && !cpu.count_wr
    |=> count_value == 8'($past(count_value) + CNT_STEP))
    else $error("normal mode did not increment");

  AST_NORMAL_OVF: assert property (
    timer_tick && cfg.mode == MODE_NORMAL && !cpu.count_wr && count_value == CNT_MAX
    |=> overflow_flag && count_value == CNT_BOTTOM)
    else $error("normal wrap without overflow flag");

  AST_CTC_CLEAR: assert property (
    timer_tick && cfg.mode == MODE_CTC && !cpu.count_wr && match_a
    |=> count_value == CNT_BOTTOM)
    else $error("ctc match did not clear counter");

  AST_CTC_TOGGLE: assert property (
    timer_tick && cfg.mode == MODE_CTC && cfg.setting_a == OUT_TOGGLE && match_a
    |=> state_reg.a.oc != $past(state_reg.a.oc))
    else $error("ctc toggle missing");

  AST_FAST_WRAP: assert property (
    timer_tick && fast && at_top && !cpu.count_wr
    |=> count_value == CNT_BOTTOM ##0 overflow_flag)
    else $error("fast pwm did not wrap at top");

  AST_PC_TURN: assert property (
    timer_tick && pc && !state_reg.down && at_top && top != CNT_BOTTOM && !cpu.count_wr
    |=> state_reg.down && count_value == 8'($past(count_value) - CNT_STEP))
    else $error("phase correct did not reverse at top");

  AST_FLAG_NEXT: assert property (
    timer_tick && match_a ##1 (!timer_tick)[*2] ##1 timer_tick
    |=> compare_flag_a)
    else $error("compare flag not set after match");

  AST_WR_PRIO: assert property (
    cpu.count_wr |=> count_value == $past(cpu.data) && state_reg.blk)
    else $error("counter write lost");

  AST_BLOCK: assert property (
    state_reg.blk && timer_tick |=> !state_reg.a.pend && !state_reg.b.pend)
    else $error("match not blocked after write");

  AST_PIN_DIR: assert property (
    ##1 compare_output_a_oe == $past(cfg.dir_a) && compare_output_b_oe == $past(cfg.dir_b))
    else $error("pin enable not following direction");

  AST_DIRECT: assert property (
    cpu.cmp_a_wr && !pwm |=> compare_value_a == $past(cpu.data))
    else $error("direct compare write lost");

  // Ticks usually run back to back, so the spaced form above seldom fires
  AST_FLAG_B2B: assert property (
    timer_tick && match_a ##1 timer_tick |=> compare_flag_a)
    else $error("compare flag not set on back to back ticks");

  AST_CTC_OVF: assert property (
    timer_tick && cfg.mode == MODE_CTC && count_value == CNT_MAX |=> overflow_flag)
    else $error("ctc wrap without overflow flag");

  AST_PC_OVF: assert property (
    timer_tick && pc && state_reg.down && count_value == CNT_STEP |=> overflow_flag)
    else $error("phase correct bottom without overflow flag");

  AST_FAST_LOAD: assert property (
    timer_tick && fast && at_top |=> compare_value_a == $past(state_reg.a.buffer))
    else $error("buffered compare not loaded at top");

  // A buffered write must not act before the boundary, or pulses get odd lengths
  AST_HOLD_BUF: assert property (
    cpu.cmp_a_wr && pwm && !(timer_tick && at_top)
    |=> compare_value_a == $past(compare_value_a))
    else $error("buffered compare acted early");

  AST_FAST_TOGGLE: assert property (
    timer_tick && fast && cfg.setting_a == OUT_TOGGLE && match_a
    |=> state_reg.a.oc != $past(state_reg.a.oc))
    else $error("fast pwm toggle missing");

  AST_FAST_MATCH: assert property (
    timer_tick && fast && cfg.setting_a == OUT_CLEAR && match_a && !at_top
    |=> !state_reg.a.oc)
    else $error("fast pwm match did not clear output");

  AST_FAST_BOTTOM: assert property (
    timer_tick && fast && at_top && cfg.setting_a == OUT_CLEAR |=> state_reg.a.oc)
    else $error("fast pwm bottom did not set output");

  AST_PC_UP: assert property (
    timer_tick && pc && !state_reg.down && !at_top && match_a
    && cfg.setting_a == OUT_CLEAR |=> !state_reg.a.oc)
    else $error("phase correct up match did not clear output");

  AST_PC_DOWN: assert property (
    timer_tick && pc && state_reg.down && count_value != CNT_BOTTOM && match_a
    && cfg.setting_a == OUT_CLEAR |=> state_reg.a.oc)
    else $error("phase correct down match did not set output");

  AST_PIN_SRC: assert property (
    cfg.setting_a != OUT_NONE |=> compare_output_a == state_reg.a.oc)
    else $error("pin not driven from compare output");

  AST_CNT_HOLD: assert property (
    !timer_tick && !cpu.count_wr |=> count_value == $past(count_value))
    else $error("counter moved without a tick");

  COV_NORMAL_OVF: cover property (timer_tick && cfg.mode == MODE_NORMAL
                                  && count_value == CNT_MAX);
  COV_CTC_MATCH:  cover property (timer_tick && cfg.mode == MODE_CTC && match_a);
  COV_FAST_TOP:   cover property (timer_tick && fast && at_top);
  COV_PC_TURN:    cover property (timer_tick && pc && at_top && !state_reg.down);

endmodule

`default_nettype wire

// [testbench/tb_eight_bit_timer_waveform_modes.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_eight_bit_timer_waveform_modes
  import timer_pkg::*;
;

  // ==========================================================================
  // Stimulus and observed signals
  localparam logic [2:0] W_CNT = 3'h1;
  localparam logic [2:0] W_CMP = 3'h2;
  localparam logic [2:0] W_CLR = 3'h4;

  logic       clock;
  logic       rstn;
  logic       timer_tick;
  cfg_s       cfg;
  cpu_s       cpu;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic       overflow_flag;
  logic       compare_flag_a;
  logic       compare_flag_b;
  logic       compare_output_a;
  logic       compare_output_a_oe;
  logic       compare_output_b;
  logic       compare_output_b_oe;
  int         bad_count;
  int         comparisons;

  pwm_timer pwm_timer_i (
    .clock, .rstn, .timer_tick, .cfg, .cpu, .count_value, .compare_value_a,
    .compare_value_b, .overflow_flag, .compare_flag_a, .compare_flag_b,
    .compare_output_a, .compare_output_a_oe, .compare_output_b, .compare_output_b_oe
  );

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ticks run back to back; entered and left at a falling edge
  task automatic step(input int n);
    timer_tick = 1'b1;
    repeat (n) @(negedge clock);
    timer_tick = 1'b0;
  endtask

  // Compare writes go to both channels so channel B logic is exercised too
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    cpu.count_wr  = sel[0];
    cpu.cmp_a_wr  = sel[1];
    cpu.cmp_b_wr  = sel[1];
    cpu.data      = d;
    cpu.clr_ovf   = sel[2];
    cpu.clr_cmp_a = sel[2];
    cpu.clr_cmp_b = sel[2];
    @(negedge clock);
    cpu = '0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check(count_value, 8'h00);
    check(overflow_flag, 1'b0);
    check(compare_output_a_oe, 1'b0);
    cfg.dir_a = 1'b1;
    cfg.dir_b = 1'b1;
    @(negedge clock);
    check(compare_output_a_oe, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_normal;
    cfg.mode      = MODE_NORMAL;
    cfg.setting_a = OUT_SET;
    wr(W_CNT, 8'hff);
    step(1);
    check(count_value, 8'h00);
    check(overflow_flag, 1'b1);
    wr(W_CLR, 8'h00);
    check(overflow_flag, 1'b0);
    step(2);
    check(count_value, 8'h02);
    $display("test normal done");
  endtask

  task automatic t_block;
    wr(W_CMP, 8'h10);
    check(compare_value_a, 8'h10);
    wr(W_CNT, 8'h10);
    wr(W_CLR, 8'h00);
    step(2);
    check(count_value, 8'h12);
    check(compare_flag_a, 1'b0);
    // Write and tick share one edge: the write must win
    timer_tick = 1'b1;
    wr(W_CNT, 8'h40);
    timer_tick = 1'b0;
    check(count_value, 8'h40);
    $display("test block done");
  endtask

  task automatic t_ctc;
    logic o;
    cfg.mode      = MODE_CTC;
    cfg.setting_a = OUT_TOGGLE;
    wr(W_CMP, 8'h03);
    wr(W_CNT, 8'h00);
    wr(W_CLR, 8'h00);
    step(3);
    check(count_value, 8'h03);
    o = compare_output_a;
    step(1);
    check(count_value, 8'h00);
    check(compare_output_a, {7'h0, ~o});
    check(compare_flag_a, 1'b0);
    step(1);
    check(compare_flag_a, 1'b1);
    check(compare_flag_b, 1'b1);
    check(compare_value_b, 8'h03);
    check(compare_output_b_oe, 1'b1);
    check(compare_output_b, 1'b0);
    cfg.port_b = 1'b1;
    @(negedge clock);
    check(compare_output_b, 1'b1);
    check(overflow_flag, 1'b0);
    wr(W_CMP, 8'h00);
    step(254);
    check(count_value, 8'hff);
    step(1);
    check(count_value, 8'h00);
    check(overflow_flag, 1'b1);
    $display("test ctc done");
  endtask

  task automatic t_fast;
    cfg.mode      = MODE_FAST_MAX;
    cfg.setting_a = OUT_CLEAR;
    wr(W_CMP, 8'h80);
    check(compare_value_a, 8'h00);
    wr(W_CNT, 8'hfe);
    wr(W_CLR, 8'h00);
    step(2);
    check(count_value, 8'h00);
    check(overflow_flag, 1'b1);
    check(compare_value_a, 8'h80);
    check(compare_output_a, 1'b1);
    step(8'h80);
    check(compare_output_a, 1'b1);
    step(1);
    check(count_value, 8'h81);
    check(compare_output_a, 1'b0);
    $display("test fast done");
  endtask

  task automatic t_pc;
    cfg.mode = MODE_PC_MAX;
    wr(W_CNT, 8'hfd);
    wr(W_CLR, 8'h00);
    step(2);
    check(count_value, 8'hff);
    step(1);
    check(count_value, 8'hfe);
    step(8'h7e);
    check(count_value, 8'h80);
    step(1);
    check(compare_output_a, 1'b1);
    check(overflow_flag, 1'b0);
    step(8'h7f);
    check(count_value, 8'h00);
    check(overflow_flag, 1'b1);
    step(8'h81);
    check(count_value, 8'h81);
    check(compare_output_a, 1'b0);
    $display("test phase correct done");
  endtask

  task automatic t_fast_top;
    logic o;
    cfg.mode      = MODE_FAST_OCR;
    cfg.setting_a = OUT_TOGGLE;
    wr(W_CMP, 8'h04);
    wr(W_CNT, 8'h7f);
    step(2);
    check(count_value, 8'h00);
    check(compare_value_a, 8'h04);
    o = compare_output_a;
    step(5);
    check(count_value, 8'h00);
    check(compare_output_a, {7'h0, ~o});
    step(5);
    check(compare_output_a, {7'h0, o});
    $display("test fast top done");
  endtask

  task automatic t_pc_zero;
    cfg.mode      = MODE_PC_MAX;
    cfg.setting_a = OUT_CLEAR;
    wr(W_CMP, 8'h00);
    wr(W_CNT, 8'hfe);
    step(2);
    check(compare_value_a, 8'h00);
    step(8'hfe);
    check(count_value, 8'h00);
    step(1);
    check(compare_output_a, 1'b0);
    step(8'h80);
    check(compare_output_a, 1'b0);
    $display("test phase correct zero done");
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Bounded run: hitting the limit counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  initial begin
    bad_count   = 0;
    comparisons = 0;
    rstn        = 1'b0;
    timer_tick  = 1'b0;
    cfg         = '0;
    cpu         = '0;
    repeat (20) @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_normal();
    t_block();
    t_ctc();
    t_fast();
    t_pc();
    t_fast_top();
    t_pc_zero();
    give_verdict();
  end

endmodule

`default_nettype wire
